//--- include/instr_timing_pkg.sv
// constants, types and helpers shared by the instruction cycle timing block
package instr_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned  SYS_CLOCK_MHZ    = 125;      // system clock rate
    localparam int unsigned  CLOCKS_PER_INSTR = 4;        // system clocks per instruction cycle
    localparam logic [1:0]   PHASE_FIRST      = 2'h0;
    localparam logic [1:0]   PHASE_LAST       = 2'(CLOCKS_PER_INSTR - 1);
    localparam logic [1:0]   PHASE_STEP       = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // data memory map as seen by this block
    localparam logic [7:0]   PROGRAM_COUNTER_LOW_BYTE_ADDR = 8'h06;
    localparam logic [7:0]   BYTE_ZERO        = 8'h00;
    localparam logic [7:0]   BYTE_ONE         = 8'h01;
    localparam logic [7:0]   ACC_RESET        = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [4:0] {
        nop_op,
        transfer_op_to_acc,
        transfer_op_to_mem,
        transfer_op_imm,
        add_mem_op,
        add_imm_op,
        adc_op,
        sub_mem_op,
        sub_imm_op,
        sbc_op,
        plus_one_op,
        plus_one_to_acc_op,
        minus_one_op,
        minus_one_to_acc_op,
        clear_op,
        jump_op,
        call_op,
        return_op,
        interrupt_return_op,
        table_read_op,
        skip_if_zero_op
    } op_t;

    typedef enum logic [1:0] {
        alu_add,
        alu_adc,
        alu_sub,
        alu_sbc
    } alu_mode_t;

    typedef struct packed {
        op_t        op;
        logic [7:0] addr;
        logic [7:0] imm;
    } instr_t;

    typedef struct packed {
        logic z;
        logic c;
        logic ac;
        logic ov;
    } flags_t;

    localparam flags_t FLAGS_RESET = '0;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // true when the instruction writes its result to data memory
    function automatic logic writes_mem(input op_t op);
        case (op)
            transfer_op_to_mem, plus_one_op, minus_one_op, clear_op: writes_mem = 1'b1;
            default: writes_mem = 1'b0;
        endcase
    endfunction : writes_mem

    // true when the instruction needs a second instruction cycle
    function automatic logic needs_extra(input op_t op, input logic [7:0] addr,
                                         input logic [7:0] rdata);
        case (op)
            jump_op, call_op, return_op, interrupt_return_op, table_read_op: needs_extra = 1'b1;
            skip_if_zero_op: needs_extra = (rdata == BYTE_ZERO);
            default: needs_extra = writes_mem(op) && (addr == PROGRAM_COUNTER_LOW_BYTE_ADDR);
        endcase
    endfunction : needs_extra

    // true for the ops that use the immediate operand
    function automatic logic uses_imm(input op_t op);
        uses_imm = (op == add_imm_op) || (op == sub_imm_op) || (op == transfer_op_imm);
    endfunction : uses_imm

endpackage : instr_timing_pkg

//--- rtl/byte_adder.sv
// eight-bit adder and subtractor with carry, borrow, half carry and overflow
`timescale 1ns/1ns
`default_nettype none

module byte_adder (
    // operands
    input  wire logic [7:0]                  a,
    input  wire logic [7:0]                  b,
    input  wire logic                        carry_in,
    input  wire instr_timing_pkg::alu_mode_t mode,
    // results
    output logic      [7:0]                  result,
    output instr_timing_pkg::flags_t         flags
);

    logic       is_sub;
    logic       use_carry;
    logic [7:0] b_eff;
    logic       cin_eff;
    logic [8:0] sum9;
    logic [4:0] low5;

    ////////////////////////////////////////////////////////////////////////////
    // subtraction is addition of the inverted operand
    assign is_sub    = (mode == instr_timing_pkg::alu_sub) || (mode == instr_timing_pkg::alu_sbc);
    assign use_carry = (mode == instr_timing_pkg::alu_adc) || (mode == instr_timing_pkg::alu_sbc);
    assign b_eff     = is_sub ? ~b : b;
    assign cin_eff   = is_sub ? ~(use_carry & carry_in) : (use_carry & carry_in);

    // nine-bit sum keeps the carry out of bit 7
    assign sum9   = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
    assign low5   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    assign result = sum9[7:0];

    // carry flag holds carry on add and borrow on subtract
    assign flags.c  = is_sub ? ~sum9[8] : sum9[8];
    assign flags.ac = is_sub ? ~low5[4] : low5[4];
    assign flags.ov = (a[7] == b_eff[7]) && (sum9[7] != a[7]);
    assign flags.z  = (sum9[7:0] == instr_timing_pkg::BYTE_ZERO);

endmodule : byte_adder

`default_nettype wire

//--- rtl/instr_cycle_timing.sv
// instruction cycle sequencer and accumulator datapath of the core
`timescale 1ns/1ns
`default_nettype none

//Function
// - ordinary instructions finish in one instruction cycle
// - branch, call and table read instructions take two instruction cycles
// - one instruction cycle is four system clock cycles
// - jump, call, return, interrupt return and table read get one extra cycle
// - writing the program counter low byte acts as a jump, one extra cycle
// - a taken skip costs one extra cycle, an untaken skip none
// - moves: memory to accumulator, accumulator to memory, immediate to accumulator
// - adder flags carry above 255 and borrow below 0
// - add-one and subtract-one instructions on a given operand
// - add, subtract and carry forms update zero, carry, half carry, overflow
module instr_cycle_timing (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // instruction and operand from the core
    input  wire logic                     instr_valid,
    input  wire instr_timing_pkg::instr_t instr,
    input  wire logic [7:0]               mem_rdata,
    // sequencing status
    output logic                          cycle_end,
    output logic                          instr_done,
    output logic                          extra_cycle,
    output logic                          flow_change,
    // data memory write
    output logic                          mem_we,
    output logic [7:0]                    mem_addr,
    output logic [7:0]                    mem_wdata,
    // accumulator and flags
    output logic [7:0]                    acc,
    output instr_timing_pkg::flags_t      flags
);

    typedef struct packed {
        logic [1:0]               phase;
        logic                     extra;
        logic                     cycle_end;
        logic                     instr_done;
        logic                     flow_change;
        logic                     mem_we;
        logic [7:0]               mem_addr;
        logic [7:0]               mem_wdata;
        logic [7:0]               acc;
        instr_timing_pkg::flags_t flags;
    } state_t;

    state_t                       state_reg;
    state_t                       state_next;
    logic [7:0]                   alu_b;
    logic [7:0]                   alu_result;
    instr_timing_pkg::flags_t     alu_flags;
    instr_timing_pkg::alu_mode_t  alu_mode;
    logic [7:0]                   plus_one;
    logic [7:0]                   minus_one;
    logic                         take;

    ////////////////////////////////////////////////////////////////////////////
    // adder operand select
    assign alu_b     = instr_timing_pkg::uses_imm(instr.op) ? instr.imm : mem_rdata;
    assign plus_one  = mem_rdata + instr_timing_pkg::BYTE_ONE;
    assign minus_one = mem_rdata - instr_timing_pkg::BYTE_ONE;
    // an instruction is taken on the last clock of a cycle that is not a dummy
    assign take      = (state_reg.phase == instr_timing_pkg::PHASE_LAST) && !state_reg.extra
                       && instr_valid;

    // adder mode from the opcode
    always_comb begin
        case (instr.op)
            instr_timing_pkg::adc_op:     alu_mode = instr_timing_pkg::alu_adc;
            instr_timing_pkg::sub_mem_op: alu_mode = instr_timing_pkg::alu_sub;
            instr_timing_pkg::sub_imm_op: alu_mode = instr_timing_pkg::alu_sub;
            instr_timing_pkg::sbc_op:     alu_mode = instr_timing_pkg::alu_sbc;
            default:                      alu_mode = instr_timing_pkg::alu_add;
        endcase
    end

    byte_adder u_adder (
        .a        (state_reg.acc),
        .b        (alu_b),
        .carry_in (state_reg.flags.c),
        .mode     (alu_mode),
        .result   (alu_result),
        .flags    (alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state: phase counter, extra cycle and execution
    always_comb begin
        state_next             = state_reg;
        state_next.cycle_end   = 1'b0;
        state_next.instr_done  = 1'b0;
        state_next.flow_change = 1'b0;
        state_next.mem_we      = 1'b0;
        state_next.phase       = state_reg.phase + instr_timing_pkg::PHASE_STEP;
        if (state_reg.phase == instr_timing_pkg::PHASE_LAST) begin
            state_next.cycle_end = 1'b1;
            if (state_reg.extra) begin
                state_next.extra = 1'b0;
            end else if (take) begin
                state_next.instr_done  = 1'b1;
                state_next.extra       = instr_timing_pkg::needs_extra(instr.op, instr.addr,
                                                                      mem_rdata);
                state_next.flow_change = state_next.extra;
                state_next.mem_addr    = instr.addr;
                case (instr.op)
                    instr_timing_pkg::transfer_op_to_acc: begin
                        state_next.acc = mem_rdata;
                    end
                    instr_timing_pkg::transfer_op_imm: begin
                        state_next.acc = instr.imm;
                    end
                    instr_timing_pkg::transfer_op_to_mem: begin
                        state_next.mem_we    = 1'b1;
                        state_next.mem_wdata = state_reg.acc;
                    end
                    instr_timing_pkg::add_mem_op, instr_timing_pkg::add_imm_op,
                    instr_timing_pkg::adc_op, instr_timing_pkg::sub_mem_op,
                    instr_timing_pkg::sub_imm_op, instr_timing_pkg::sbc_op: begin
                        state_next.acc   = alu_result;
                        state_next.flags = alu_flags;
                    end
                    instr_timing_pkg::plus_one_op: begin
                        state_next.mem_we    = 1'b1;
                        state_next.mem_wdata = plus_one;
                        state_next.flags.z   = (plus_one == instr_timing_pkg::BYTE_ZERO);
                    end
                    instr_timing_pkg::plus_one_to_acc_op: begin
                        state_next.acc     = plus_one;
                        state_next.flags.z = (plus_one == instr_timing_pkg::BYTE_ZERO);
                    end
                    instr_timing_pkg::minus_one_op: begin
                        state_next.mem_we    = 1'b1;
                        state_next.mem_wdata = minus_one;
                        state_next.flags.z   = (minus_one == instr_timing_pkg::BYTE_ZERO);
                    end
                    instr_timing_pkg::minus_one_to_acc_op: begin
                        state_next.acc     = minus_one;
                        state_next.flags.z = (minus_one == instr_timing_pkg::BYTE_ZERO);
                    end
                    instr_timing_pkg::clear_op: begin
                        state_next.mem_we    = 1'b1;
                        state_next.mem_wdata = instr_timing_pkg::BYTE_ZERO;
                    end
                    default: begin
                        state_next.mem_we = 1'b0; // control transfer handled by the core
                    end
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= '0;
            state_reg.acc   <= instr_timing_pkg::ACC_RESET;
            state_reg.flags <= instr_timing_pkg::FLAGS_RESET;
            state_reg.phase <= instr_timing_pkg::PHASE_FIRST;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign cycle_end   = state_reg.cycle_end;
    assign instr_done  = state_reg.instr_done;
    assign extra_cycle = state_reg.extra;
    assign flow_change = state_reg.flow_change;
    assign mem_we      = state_reg.mem_we;
    assign mem_addr    = state_reg.mem_addr;
    assign mem_wdata   = state_reg.mem_wdata;
    assign acc         = state_reg.acc;
    assign flags       = state_reg.flags;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_single_cycle;
        @(posedge clock) disable iff (!rst_n)
        instr_done && !instr_timing_pkg::needs_extra($past(instr.op), $past(instr.addr),
                                                     $past(mem_rdata)) |-> !extra_cycle;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("ordinary op got extra cycle");

    property p_two_cycles;
        @(posedge clock) disable iff (!rst_n)
        instr_done && extra_cycle |=> (!instr_done)[*7];
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("two-cycle op ended early");

    property p_four_clocks;
        @(posedge clock) disable iff (!rst_n)
        cycle_end |=> (!cycle_end)[*3] ##1 cycle_end;
    endproperty
    a_four_clocks: assert property (p_four_clocks) else $error("cycle not four clocks");

    property p_branch_extra;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) inside {instr_timing_pkg::jump_op,
            instr_timing_pkg::call_op, instr_timing_pkg::return_op,
            instr_timing_pkg::interrupt_return_op, instr_timing_pkg::table_read_op})
        |-> extra_cycle && flow_change;
    endproperty
    a_branch_extra: assert property (p_branch_extra) else $error("branch without extra");

    property p_pcl_write;
        @(posedge clock) disable iff (!rst_n)
        mem_we && (mem_addr == instr_timing_pkg::PROGRAM_COUNTER_LOW_BYTE_ADDR)
        |-> extra_cycle && flow_change;
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("pcl write without extra");

    property p_skip;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::skip_if_zero_op)
        |-> extra_cycle == ($past(mem_rdata) == instr_timing_pkg::BYTE_ZERO);
    endproperty
    a_skip: assert property (p_skip) else $error("skip timing wrong");

    property p_move_imm;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::transfer_op_imm)
        |-> acc == $past(instr.imm) && !mem_we;
    endproperty
    a_move_imm: assert property (p_move_imm) else $error("immediate move wrong");

    property p_add_carry;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::add_mem_op)
        |-> flags.c == (({1'b0, $past(state_reg.acc)} + {1'b0, $past(mem_rdata)}) > 9'h0ff);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_borrow;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::sub_mem_op)
        |-> flags.c == ($past(mem_rdata) > $past(state_reg.acc));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

    property p_inc_acc;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::plus_one_to_acc_op)
        |-> acc == 8'($past(mem_rdata) + 8'h01) && !mem_we;
    endproperty
    a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

    property p_zero_flag;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) inside {instr_timing_pkg::add_mem_op,
            instr_timing_pkg::adc_op, instr_timing_pkg::sub_mem_op})
        |-> flags.z == (acc == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_dec_mem;
        @(posedge clock) disable iff (!rst_n)
        instr_done && ($past(instr.op) == instr_timing_pkg::minus_one_op)
        |-> mem_we && mem_wdata == 8'($past(mem_rdata) - 8'h01) && acc == $past(state_reg.acc);
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("decrement to memory wrong");

endmodule : instr_cycle_timing

`default_nettype wire

//--- verif/instr_cycle_timing_bench.sv
// self-checking bench for the instruction cycle timing block
`timescale 1ns/1ns
`default_nettype none

module instr_cycle_timing_bench;

    ////////////////////////////////////////////////////////////////////////////
    // signals
    logic                     clock;
    logic                     rst_n;
    logic                     instr_valid;
    instr_timing_pkg::instr_t instr;
    logic [7:0]               mem_rdata;
    logic                     cycle_end;
    logic                     instr_done;
    logic                     extra_cycle;
    logic                     flow_change;
    logic                     mem_we;
    logic [7:0]               mem_addr;
    logic [7:0]               mem_wdata;
    logic [7:0]               acc;
    instr_timing_pkg::flags_t flags;
    logic [7:0]               mem [256];
    logic [7:0]               e_acc;
    instr_timing_pkg::flags_t e_flags;
    logic                     e_two;
    logic                     e_two_prev;
    int                       miscompares;
    int                       cmp_count;
    int                       cycles = 0;
    int                       seed;
    int                       i;

    instr_cycle_timing uut (
        .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .mem_rdata(mem_rdata), .cycle_end(cycle_end), .instr_done(instr_done),
        .extra_cycle(extra_cycle), .flow_change(flow_change), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .acc(acc), .flags(flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // data memory of the core, read combinationally, written by the block
    assign mem_rdata = mem[instr.addr];
    always @(posedge clock) begin
        if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    end

    // clock and cycle ceiling
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // expected result: {z, c, ac, ov, result}
    function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic sub);
        logic [8:0] r;
        logic [4:0] h;
        logic       ov;
        if (sub) begin
            r  = {1'b0, a} - {1'b0, b} - 9'(cin);
            h  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin);
            ov = (a[7] != b[7]) && (r[7] != a[7]);
        end else begin
            r  = {1'b0, a} + {1'b0, b} + 9'(cin);
            h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
            ov = (a[7] == b[7]) && (r[7] != a[7]);
        end
        alu = {r[7:0] == 8'h00, r[8], h[4], ov, r[7:0]};
    endfunction : alu

    ////////////////////////////////////////////////////////////////////////////
    // present one instruction at a falling edge, wait for it, check the outcome
    task automatic issue(input instr_timing_pkg::op_t op, input logic [7:0] addr,
                         input logic [7:0] imm);
        logic [11:0] r;
        logic [7:0]  m;
        logic [7:0]  wd;
        logic        we;
        int          n;
        instr_valid = 1'b1;
        instr = '{op: op, addr: addr, imm: imm};
        @(negedge clock);
        n = 1;
        m = mem[addr];
        r = {e_flags, e_acc};
        we = 1'b0;
        wd = e_acc;
        e_two = 1'b0;
        case (op)
            instr_timing_pkg::transfer_op_to_acc:  r[7:0] = m;
            instr_timing_pkg::transfer_op_to_mem:  we = 1'b1;
            instr_timing_pkg::transfer_op_imm:     r[7:0] = imm;
            instr_timing_pkg::add_mem_op:          r = alu(e_acc, m, 1'b0, 1'b0);
            instr_timing_pkg::add_imm_op:          r = alu(e_acc, imm, 1'b0, 1'b0);
            instr_timing_pkg::adc_op:              r = alu(e_acc, m, e_flags.c, 1'b0);
            instr_timing_pkg::sub_mem_op:          r = alu(e_acc, m, 1'b0, 1'b1);
            instr_timing_pkg::sub_imm_op:          r = alu(e_acc, imm, 1'b0, 1'b1);
            instr_timing_pkg::sbc_op:              r = alu(e_acc, m, e_flags.c, 1'b1);
            instr_timing_pkg::plus_one_op: begin
                we = 1'b1;
                wd = m + 8'h01;
                r[11] = (wd == 8'h00);
            end
            instr_timing_pkg::minus_one_op: begin
                we = 1'b1;
                wd = m - 8'h01;
                r[11] = (wd == 8'h00);
            end
            instr_timing_pkg::plus_one_to_acc_op: begin
                r[7:0] = m + 8'h01;
                r[11] = (r[7:0] == 8'h00);
            end
            instr_timing_pkg::minus_one_to_acc_op: begin
                r[7:0] = m - 8'h01;
                r[11] = (r[7:0] == 8'h00);
            end
            instr_timing_pkg::clear_op: begin
                we = 1'b1;
                wd = 8'h00;
            end
            instr_timing_pkg::skip_if_zero_op:     e_two = (m == 8'h00);
            instr_timing_pkg::nop_op:              ;
            default:                               e_two = 1'b1;
        endcase
        if (we && addr == instr_timing_pkg::PROGRAM_COUNTER_LOW_BYTE_ADDR) e_two = 1'b1;
        while (instr_done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n = n + 1;
        end
        chk(16'(n), e_two_prev ? 16'd8 : 16'd4);
        chk(16'(cycle_end), 16'h0001);
        chk(16'(extra_cycle), 16'(e_two));
        chk(16'(flow_change), 16'(e_two));
        chk(16'(mem_we), 16'(we));
        chk(16'(mem_addr), 16'(addr));
        if (we) chk(16'(mem_wdata), 16'(wd));
        chk(16'(acc), 16'(r[7:0]));
        chk(16'(flags), 16'(r[11:8]));
        e_acc = r[7:0];
        e_flags = r[11:8];
        e_two_prev = e_two;
    endtask : issue

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 49;
        miscompares = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        e_acc = 8'h00;
        e_flags = '0;
        e_two_prev = 1'b0;
        for (i = 0; i < 256; i++) mem[i] = 8'($random(seed));
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        // carry above 255 and borrow below 0
        issue(instr_timing_pkg::transfer_op_imm, 8'h20, 8'hff);
        issue(instr_timing_pkg::add_imm_op, 8'h20, 8'h01);
        chk(16'(flags.c), 16'h0001);
        issue(instr_timing_pkg::sub_imm_op, 8'h20, 8'h01);
        chk(16'(flags.c), 16'h0001);
        // every op once
        for (i = 0; i < 21; i++) begin
            issue(instr_timing_pkg::op_t'(i), 8'($random(seed)), 8'($random(seed)));
        end
        // writes to the program counter low byte
        issue(instr_timing_pkg::transfer_op_to_mem, 8'h06, 8'h00);
        chk(16'(extra_cycle), 16'h0001);
        issue(instr_timing_pkg::plus_one_op, 8'h06, 8'h00);
        chk(16'(flow_change), 16'h0001);
        // taken and untaken skip
        issue(instr_timing_pkg::transfer_op_imm, 8'h10, 8'h00);
        issue(instr_timing_pkg::transfer_op_to_mem, 8'h10, 8'h00);
        issue(instr_timing_pkg::skip_if_zero_op, 8'h10, 8'h00);
        chk(16'(extra_cycle), 16'h0001);
        issue(instr_timing_pkg::plus_one_op, 8'h10, 8'h00);
        issue(instr_timing_pkg::skip_if_zero_op, 8'h10, 8'h00);
        chk(16'(extra_cycle), 16'h0000);
        // random traffic, back to back
        for (i = 0; i < 300; i++) begin
            issue(instr_timing_pkg::op_t'(5'($unsigned($random(seed)) % 21)),
                  8'($random(seed)), 8'($random(seed)));
        end
        // reset in mid-run
        rst_n = 1'b0;
        @(negedge clock);
        chk(16'(acc), 16'(instr_timing_pkg::ACC_RESET));
        chk(16'(flags), 16'(instr_timing_pkg::FLAGS_RESET));
        rst_n = 1'b1;
        e_acc = 8'h00;
        e_flags = '0;
        e_two_prev = 1'b0;
        for (i = 0; i < 20; i++) begin
            issue(instr_timing_pkg::op_t'(5'($unsigned($random(seed)) % 21)),
                  8'($random(seed)), 8'($random(seed)));
        end
        give_verdict();
    end

endmodule : instr_cycle_timing_bench

`default_nettype wire
